// [shared/eei_consts.vh]
`ifndef EEI_CONSTS_VH
`define EEI_CONSTS_VH

// ****************************************************************
// array geometry
// ****************************************************************
`define EE_MEM_DEPTH    2048
`define EE_ADDR_W       11
`define EE_PAGE_BYTES   16
`define EE_PAGE_W       7
`define EE_OFS_W        4
`define EE_PROT_BIT     10

// ****************************************************************
// device address byte
// ****************************************************************
`define EE_TYPE_MSB     7
`define EE_TYPE_LSB     4
`define EE_HI_MSB       3
`define EE_HI_LSB       1
`define EE_RW_BIT       0
`define EE_RW_READ      1'h1
// type code value is arbitrary, not tied to any part
`define EE_TYPE_CODE    4'h5

// ****************************************************************
// byte framing
// ****************************************************************
`define EE_BYTE_BITS    4'h8
`define EE_KIND_DEV     2'h0
`define EE_KIND_ADDR    2'h1
`define EE_KIND_DATA    2'h2

// ****************************************************************
// timing
// ****************************************************************
`define EE_CLK_KHZ      40000
`define EE_TWC_MS       10
`define EE_TMR_W        19
`define EE_SYNC_W       3

`endif

// [src/eei_sync.v]
`timescale 1ns/100ps

module eei_sync #(
  parameter W = 3
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // asynchronous levels in, clean levels out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ****************************************************************
  // two flops per bit
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      // first flop feeds only the second, never any logic
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= 1'h1;
          stage2 <= 1'h1;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

// [src/eei_target.v]
`timescale 1ns/100ps
`include "eei_consts.vh"

// Overview of operation
// - array of 2048 bytes, 128 pages of 16
// - first byte: type code, high address, direction
// - direction bit one reads, zero writes
// - receiver pulls data low on ninth clock
// - transmitter releases data after eighth bit
// - missing controller acknowledge ends read, standby
// - data falling, clock high: start
// - data rising, clock high: stop, standby
// - data changes only while clock low
// - write acknowledges device, address, every data
// - read acknowledges device, streams incrementing bytes
// - protect input high blocks upper half writes
// - unconnected protect input counts as low
// - data pin only pulled low, open drain
// - target only, never drives the clock
// - sixteen byte page latches before programming
// - stop starts write cycle, within ten ms
// - sample on clock rise, shift on fall
// - busy writing: ignore inputs, no acknowledge
// - protected stop: no cycle, ready at once

module eei_target #(
  parameter [`EE_TMR_W-1:0] WC_CYCLES = `EE_TWC_MS * `EE_CLK_KHZ
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // two-wire bus, clock is input only
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  // write protect strap
  input  wire wp_in,
  // status
  output reg  write_busy,
  output reg  link_idle
);

  // ****************************************************************
  // link states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [7:0] mem   [0:`EE_MEM_DEPTH-1];
  reg [7:0] latch [0:`EE_PAGE_BYTES-1];

  reg [`EE_PAGE_BYTES-1:0] latch_valid;
  reg [`EE_PAGE_W-1:0]     prog_page;
  reg [`EE_ADDR_W-1:0]     addr;
  reg [`EE_TMR_W-1:0]      tmr;

  reg [2:0] state;
  reg [1:0] kind;
  reg [3:0] cnt;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg       rd_mode;
  reg       ack_seen;
  reg       scl_d;
  reg       sda_d;

  wire [`EE_SYNC_W-1:0] pins_s;
  wire                  scl_s;
  wire                  sda_s;
  wire                  wp_s;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  eei_sync #(
    .W (`EE_SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({wp_in, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  // a floating strap needs no tie outside; x or z reads as unprotected
  assign wp_s  = (pins_s[2] === 1'h1);

  // ****************************************************************
  // bus events
  // ****************************************************************
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_cnd = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cnd  = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_done = (state == ST_RX) && scl_fall && (cnt == `EE_BYTE_BITS);

  // decode of the just received byte
  wire type_ok  = (rx_sh[`EE_TYPE_MSB:`EE_TYPE_LSB] == `EE_TYPE_CODE);
  wire rw_read  = (rx_sh[`EE_RW_BIT] == `EE_RW_READ);
  wire data_in  = byte_done && (kind == `EE_KIND_DATA);

  // stop in the clock after a data acknowledge; its rise shifts one bit
  wire stop_ok  = stop_cnd && (state == ST_RX) && (cnt == 4'h1) &&
                  (kind == `EE_KIND_DATA) && (|latch_valid);
  wire protect  = wp_s && prog_page[`EE_PAGE_W-1];
  wire prog_on  = write_busy && (tmr < `EE_PAGE_BYTES);
  wire [`EE_OFS_W-1:0] prog_ofs = tmr[`EE_OFS_W-1:0];

  // ****************************************************************
  // edge history, read only from synced levels
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ****************************************************************
  // page latches and array programming
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (data_in && !write_busy) begin
      latch[addr[`EE_OFS_W-1:0]] <= rx_sh;
    end
  end

  always @(posedge clk_sys) begin
    if (prog_on && latch_valid[prog_ofs]) begin
      mem[{prog_page, prog_ofs}] <= latch[prog_ofs];
    end
  end

  // ****************************************************************
  // internal write cycle timer
  // ****************************************************************
  // first sixteen ticks copy the latches, the rest pads to full time
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_busy <= 1'h0;
      tmr        <= {`EE_TMR_W{1'h0}};
    end else if (write_busy) begin
      if (tmr == WC_CYCLES - 1'h1) begin
        write_busy <= 1'h0;
        tmr        <= {`EE_TMR_W{1'h0}};
      end else begin
        tmr <= tmr + 1'h1;
      end
    end else if (stop_ok && !protect) begin
      write_busy <= 1'h1;
      tmr        <= {`EE_TMR_W{1'h0}};
    end
  end

  // ****************************************************************
  // link state machine
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      kind        <= `EE_KIND_DEV;
      cnt         <= 4'h0;
      rx_sh       <= 8'h00;
      tx_sh       <= 8'h00;
      rd_mode     <= 1'h0;
      ack_seen    <= 1'h0;
      addr        <= {`EE_ADDR_W{1'h0}};
      prog_page   <= {`EE_PAGE_W{1'h0}};
      latch_valid <= {`EE_PAGE_BYTES{1'h0}};
      sda_out     <= 1'h0;
      sda_oe      <= 1'h0;
      link_idle   <= 1'h1;
    end else if (write_busy) begin
      // whole bus ignored, so a poll sees no acknowledge
      state     <= ST_IDLE;
      sda_oe    <= 1'h0;
      link_idle <= 1'h1;
    end else if (start_cnd) begin
      state       <= ST_RX;
      kind        <= `EE_KIND_DEV;
      cnt         <= 4'h0;
      sda_oe      <= 1'h0;
      link_idle   <= 1'h0;
      latch_valid <= {`EE_PAGE_BYTES{1'h0}};
    end else if (stop_cnd) begin
      // protected page: latches dropped, link free at once
      state     <= ST_IDLE;
      sda_oe    <= 1'h0;
      link_idle <= 1'h1;
      if (stop_ok && protect) begin
        latch_valid <= {`EE_PAGE_BYTES{1'h0}};
      end
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe    <= 1'h0;
          link_idle <= 1'h1;
        end

        ST_RX: begin
          if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], sda_s};
            cnt   <= cnt + 4'h1;
          end else if (byte_done) begin
            cnt <= 4'h0;
            case (kind)
              `EE_KIND_DEV: begin
                if (type_ok) begin
                  sda_oe  <= 1'h1;
                  state   <= ST_ACK;
                  rd_mode <= rw_read;
                  if (!rw_read) begin
                    addr[`EE_ADDR_W-1:8] <= rx_sh[`EE_HI_MSB:`EE_HI_LSB];
                  end
                end else begin
                  // foreign type code: stay off the bus
                  state     <= ST_IDLE;
                  link_idle <= 1'h1;
                end
              end
              `EE_KIND_ADDR: begin
                addr[7:0] <= rx_sh;
                sda_oe    <= 1'h1;
                state     <= ST_ACK;
              end
              default: begin
                // data byte: mark latch, wrap inside the page
                latch_valid[addr[`EE_OFS_W-1:0]] <= 1'h1;
                prog_page <= addr[`EE_ADDR_W-1:`EE_OFS_W];
                addr[`EE_OFS_W-1:0] <=
                  addr[`EE_OFS_W-1:0] + 4'h1;
                sda_oe <= 1'h1;
                state  <= ST_ACK;
              end
            endcase
          end
        end

        ST_ACK: begin
          // acknowledge held through the whole ninth clock
          if (scl_fall) begin
            cnt <= 4'h0;
            if (kind == `EE_KIND_DEV && rd_mode) begin
              tx_sh  <= {mem[addr][6:0], 1'h0};
              sda_oe <= ~mem[addr][7];
              addr   <= addr + 1'h1;
              state  <= ST_TX;
            end else begin
              sda_oe <= 1'h0;
              state  <= ST_RX;
              if (kind == `EE_KIND_DEV) begin
                kind <= `EE_KIND_ADDR;
              end else begin
                kind <= `EE_KIND_DATA;
              end
            end
          end
        end

        ST_TX: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == `EE_BYTE_BITS) begin
              sda_oe <= 1'h0;
              cnt    <= 4'h0;
              state  <= ST_RACK;
            end else begin
              sda_oe <= ~tx_sh[7];
              tx_sh  <= {tx_sh[6:0], 1'h0};
            end
          end
        end

        ST_RACK: begin
          if (scl_rise) begin
            ack_seen <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_seen) begin
              // counter rolls over past the top address
              tx_sh  <= {mem[addr][6:0], 1'h0};
              sda_oe <= ~mem[addr][7];
              addr   <= addr + 1'h1;
              state  <= ST_TX;
            end else begin
              sda_oe    <= 1'h0;
              state     <= ST_IDLE;
              link_idle <= 1'h1;
            end
          end
        end

        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'h0;
        end
      endcase
    end
  end

  // the clock pin has no driver at all; the target only listens

endmodule

// [sim/eei_target_assertions.sv]
`timescale 1ns/100ps
`include "eei_consts.vh"

module eei_target_checker #(
  parameter [`EE_TMR_W-1:0] WC_CYCLES = 400000
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // bus and status
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire wp_in,
  input wire write_busy,
  input wire link_idle
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg [`EE_TMR_W-1:0] busy_cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else busy_cnt <= write_busy ? busy_cnt + 1'b1 : 0;
  end
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_BUSY_NO_ACK: assert property (write_busy |-> !sda_oe)
    else $error("drive while busy");
  AST_IDLE_NO_DRIVE: assert property (link_idle |-> !sda_oe)
    else $error("drive while idle");
  AST_OE_STABLE_HIGH: assert property
    ((scl_in && $past(scl_in) && $past(scl_in, 2)) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  AST_START_SCL_HIGH: assert property ($fell(link_idle) |-> scl_in)
    else $error("start seen with clock low");
  AST_BUSY_AFTER_STOP: assert property
    ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write cycle not after stop");
  AST_BUSY_HOLD: assert property ($rose(write_busy) |=> write_busy[*8])
    else $error("write cycle too short");
  AST_BUSY_LEN: assert property ($fell(write_busy) |->
    busy_cnt >= WC_CYCLES - 1 && busy_cnt <= WC_CYCLES)
    else $error("write cycle length wrong");
endmodule

bind eei_target eei_target_checker #(.WC_CYCLES(WC_CYCLES)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in),
  .write_busy(write_busy), .link_idle(link_idle));

// [sim/eei_ctrl_model.sv]
`timescale 1ns/100ps

// bus controller: makes the clock only inside frames
module eei_ctrl_model (
  // clock and bus
  input  wire  clk_sys,
  input  wire  sda_bus,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic start_cond;
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop_cond;
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(6);
  endtask
  // data moves only in the low phase, 200 ns per bit
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda_bus;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic give, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(!give, r);
  endtask
endmodule

// [sim/eei_target_tb_top.sv]
`timescale 1ns/100ps
`include "eei_consts.vh"

module eei_target_tb_top;
  // short write cycle keeps the run brief
  localparam int WC = 200;
  logic       clk_sys, rst_n, wp_in, ack;
  wire        scl, sda_low, sda_out, sda_oe, write_busy, link_idle;
  wire        sda_bus = ~(sda_oe | sda_low);
  int         mismatches, num_checks, cyc;
  logic [7:0] b;
  logic [7:0] exp_mem [0:2047];

  eei_target #(.WC_CYCLES(WC)) eei_target_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_in(wp_in), .write_busy(write_busy),
    .link_idle(link_idle));
  eei_ctrl_model eei_ctrl_model_i (.clk_sys(clk_sys), .sda_bus(sda_bus),
    .scl(scl), .sda_low(sda_low));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(string what, logic [10:0] e, logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic [7:0] dv(input [10:0] a, input logic rw);
    dv = {`EE_TYPE_CODE, a[10:8], rw};
  endfunction
  task automatic wr_seq(input [10:0] a, input int n, input [7:0] v0);
    int   polls;
    logic prot;
    prot = (wp_in === 1'b1) && a[`EE_PROT_BIT];
    eei_ctrl_model_i.start_cond();
    eei_ctrl_model_i.send(dv(a, 1'b0), ack);
    chk("dev ack", 1, ack);
    eei_ctrl_model_i.send(a[7:0], ack);
    chk("addr ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      eei_ctrl_model_i.send(v0 + i, ack);
      chk("data ack", 1, ack);
      if (!prot) exp_mem[{a[10:4], a[3:0] + i[3:0]}] = v0 + i;
    end
    eei_ctrl_model_i.stop_cond();
    if (prot) chk("busy", 0, write_busy);
    else chk("busy", 1, write_busy);
    polls = 0;
    do begin
      eei_ctrl_model_i.start_cond();
      eei_ctrl_model_i.send(dv(0, 1'b0), ack);
      eei_ctrl_model_i.stop_cond();
      polls++;
    end while (!ack && polls < 40);
    chk("poll ack", 1, ack);
    if (prot) chk("first poll", 1, polls);
    else chk("polled busy", 1, polls > 1);
  endtask
  task automatic rd_seq(input [10:0] a, input int n);
    eei_ctrl_model_i.start_cond();
    eei_ctrl_model_i.send(dv(a, 1'b0), ack);
    eei_ctrl_model_i.send(a[7:0], ack);
    eei_ctrl_model_i.start_cond();
    eei_ctrl_model_i.send(dv(a, 1'b1), ack);
    chk("read dev ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      eei_ctrl_model_i.recv(i < n - 1, b);
      chk("read data", exp_mem[a + i[10:0]], b);
    end
    // nack alone must drop the device to standby, before any stop
    eei_ctrl_model_i.tick(2);
    chk("idle after nack", 1, link_idle);
    eei_ctrl_model_i.stop_cond();
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_page_wrap;
    wr_seq(11'h053, 16, 8'h10);
    rd_seq(11'h050, 15);
    eei_ctrl_model_i.start_cond();
    eei_ctrl_model_i.send(dv(0, 1'b1), ack);
    chk("cur dev ack", 1, ack);
    eei_ctrl_model_i.recv(1'b0, b);
    chk("current read", exp_mem[11'h05f], b);
    eei_ctrl_model_i.stop_cond();
  endtask
  task automatic t_rollover;
    wr_seq(11'h7ff, 1, 8'ha0);
    wr_seq(11'h000, 1, 8'ha1);
    rd_seq(11'h7ff, 2);
  endtask
  task automatic t_protect;
    wr_seq(11'h400, 2, 8'h30);
    wp_in = 1'b1;
    wr_seq(11'h400, 2, 8'h70);
    wr_seq(11'h3fe, 2, 8'h40);
    rd_seq(11'h3fe, 4);
    wp_in = 1'bz;
    wr_seq(11'h7f0, 1, 8'h55);
    rd_seq(11'h7f0, 1);
    wp_in = 1'b0;
  endtask
  task automatic t_bad_type;
    eei_ctrl_model_i.start_cond();
    eei_ctrl_model_i.send(8'h30, ack);
    chk("foreign ack", 0, ack);
    eei_ctrl_model_i.stop_cond();
    chk("idle", 1, link_idle);
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      $display("timeout");
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    wp_in = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("idle after reset", 1, link_idle);
    chk("drive level", 0, sda_out);
    t_bad_type();
    t_page_wrap();
    t_rollover();
    t_protect();
    conclude();
  end
endmodule
